// *** src/rmwc_pkg.sv ***
// Register map, field layout, timing and types of the reset, mode and watchdog controller
package rmwc_pkg;

   // Register addresses on the special-function / secondary bus port
   localparam logic [7:0] ADDR_BOR    = 8'h2e;
   localparam logic [7:0] ADDR_CLKCFG = 8'h84;
   localparam logic [7:0] ADDR_STAT   = 8'h85;
   localparam logic [7:0] ADDR_PWR    = 8'h87;
   localparam logic [7:0] ADDR_SOFT   = 8'h8e;
   localparam logic [7:0] ADDR_WTO    = 8'h91;
   localparam logic [7:0] ADDR_WEN    = 8'h92;
   localparam logic [7:0] ADDR_CAUSE  = 8'hd7;
   localparam logic [7:0] ADDR_IRQEN  = 8'he6;
   localparam logic [7:0] ADDR_IRC1   = 8'hf1;
   localparam logic [7:0] ADDR_IRQPR  = 8'hf6;

   // Reset values
   localparam logic [7:0] RST_BOR    = 8'h18;
   localparam logic [7:0] RST_CLKCFG = 8'h01;
   localparam logic [7:0] RST_ZERO   = 8'h00;
   localparam logic [7:0] RST_CAUSE  = 8'h02;

   // Implemented bits of each register
   localparam logic [7:0] MASK_BOR    = 8'h1f;
   localparam logic [7:0] MASK_CLKCFG = 8'h07;
   localparam logic [7:0] MASK_PWR    = 8'h01;
   localparam logic [7:0] MASK_STAT   = 8'h03;
   localparam logic [7:0] MASK_WTO    = 8'h07;
   localparam logic [7:0] MASK_IRQ    = 8'hfc;

   // Key value for soft reset and watchdog stop
   localparam logic [7:0] KEY_VALUE = 8'h55;

   // Reset-cause bit positions
   localparam int CAUSE_BOOT  = 7;
   localparam int CAUSE_DEBUG = 6;
   localparam int CAUSE_SOFT  = 5;
   localparam int CAUSE_PROG  = 4;
   localparam int CAUSE_PCOVF = 3;
   localparam int CAUSE_BO    = 2;
   localparam int CAUSE_PO    = 1;
   localparam int CAUSE_WDT   = 0;

   // Other field positions
   localparam int BOR_DIS_BIT = 4;
   localparam int BOR_DLY_BIT = 3;
   localparam int WAIT_BIT    = 2;
   localparam int LOWPWR_BIT  = 0;
   localparam int STAT_WDT    = 1;
   localparam int STAT_T2     = 0;
   localparam int IRQ7_BIT    = 7;

   // Global reset hold timing
   localparam int HOLD_W        = 20;
   localparam int CLK_PERIOD_NS = 20;
   localparam int GLB_HOLD_NS   = 20000000;
   localparam logic [HOLD_W-1:0] GLB_HOLD_CYC =
      HOLD_W'((GLB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [HOLD_W-1:0] DBG_HOLD_CYC  = 20'h00001;
   localparam logic [HOLD_W-1:0] BOOT_HOLD_CYC = 20'h00003;

   // Watchdog timing in low-speed clock ticks
   localparam int WDT_W       = 17;
   localparam int LS_HZ       = 32000;
   localparam int WDT_BASE_MS = 18;
   localparam logic [WDT_W-1:0] WDT_BASE_TICKS = WDT_W'(WDT_BASE_MS * LS_HZ / 1000);

   // Pin synchroniser lanes
   localparam int SYNC_N    = 3;
   localparam int SYNC_LS   = 0;
   localparam int SYNC_BO_N = 1;
   localparam int SYNC_PROG = 2;
   localparam logic [SYNC_N-1:0] SYNC_IDLE = 3'h2;

   typedef enum logic [1:0] {
      RMWC_RUN  = 2'b01,
      RMWC_HOLD = 2'b10
   } rmwc_state_t;

   // Trip level index: 0=2.1V 1=2.8V 2=3.3V 3=3.7V 4=4.2V
   function automatic logic [2:0] rmwc_bor_level(input logic [2:0] code);
      rmwc_bor_level = code[2] ? 3'h4 : {1'b0, code[1:0]};
   endfunction

endpackage

// *** src/rmwc_top.sv ***
// Reset sequencer, working-mode control and watchdog with their registers
//
// What this block does
// RULE1: Cause bits 5,4,3: soft, programming, PC overflow
// RULE2: Cause bits 2,1,0: brown-out, power-on, watchdog
// RULE3: Cause bits 7,6: boot upgrade, trim debug
// RULE4: Cause flags survive resets, cleared by software
// RULE5: Writing 0x55 to soft-reset key resets
// RULE6: Watchdog reset holds global reset 20ms
// RULE7: Brown-out bit 4 disables detection
// RULE8: Brown-out bit 3 selects longer delay
// RULE9: Threshold code picks trip level, 1xx=4.2V
// RULE10: Brown-out config loads 0x18 on power-on only
// RULE11: Clock config bit 2 enters wait mode
// RULE12: Enabled interrupts wake chip from wait
// RULE13: Power control bit 0 enters low power
// RULE14: Hardware clears low-power bit on wake
// RULE15: Enabled listed interrupts wake from low power
// RULE16: Timeout is 18ms times two to setting
// RULE17: Normal-mode overflow causes global reset
// RULE18: Low-power overflow raises watchdog interrupt instead
// RULE19: Any timeout register write clears counter
// RULE20: Counter clear released on low-speed tick
// RULE21: Counter restarts from zero after overflow
// RULE22: 0x55 stops watchdog, other values enable
// RULE23: Status bit 1 set by watchdog interrupt
// RULE24: Shared interrupt enable and flag bit 7
// RULE25: Low-speed clock synchronised before use
// RULE26: All registers accessible on SFR port
`timescale 1ns/1ns
module rmwc_top
   import rmwc_pkg::*;
#(
   parameter logic [rmwc_pkg::HOLD_W-1:0] HOLD_CYC = rmwc_pkg::GLB_HOLD_CYC,
   parameter logic [rmwc_pkg::WDT_W-1:0]  WDT_BASE = rmwc_pkg::WDT_BASE_TICKS
) (
   input  wire logic       ref_clk,         // System clock
   input  wire logic       rst,             // Power-on reset, async
   input  wire logic [7:0] sfr_addr,        // Register address
   input  wire logic       sfr_wr,          // Write strobe
   input  wire logic       sfr_rd,          // Read strobe
   input  wire logic [7:0] sfr_wdata,       // Write data
   output logic      [7:0] sfr_rdata,       // Read data, next cycle
   input  wire logic       low_speed_osc,   // Low-speed oscillator pin
   input  wire logic       bor_trip_n,      // Brown-out comparator, low=trip
   input  wire logic       prog_en,         // Programming mode pin
   input  wire logic       pc_overflow,     // Core PC overflow
   input  wire logic       debug_rst_req,   // Trim configuration reset
   input  wire logic       boot_rst_req,    // Boot upgrade reset
   input  wire logic       timer2_irq,      // Timer2 event pulse
   input  wire logic       wake_wait_irq,   // Other enabled wait wakeups
   input  wire logic       wake_lp_irq,     // Other enabled low-power wakeups
   output logic            glb_rst,         // Global chip reset
   output logic            wait_mode,       // Wait mode active
   output logic            low_power_enter, // Low-power mode active
   output logic            core_halt,       // Core clock stopped
   output logic            periph_halt,     // UART and PWM stopped
   output logic            rc_1mhz_osc_off, // 1MHz RC and PLL stopped
   output logic            brownout_disable,      // Detector off
   output logic            brownout_delay_select, // Long delay
   output logic      [2:0] brownout_threshold_select, // Trip code
   output logic      [2:0] bor_level,       // Decoded trip level
   output logic            wdt_timer2_irq,  // Interrupt request to core
   output logic      [7:0] irq_priority_1   // Priority bits
);
   import rmwc_pkg::*;

   // Pin synchronisers
   logic [SYNC_N-1:0] sync1_r;
   logic [SYNC_N-1:0] sync2_r;
   logic [SYNC_N-1:0] pins;
   logic              ls_prev_r;
   logic              ls_tick;

   assign pins = {prog_en, bor_trip_n, low_speed_osc};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
         always_ff @(posedge ref_clk or posedge rst) begin
            // Idle pin level at reset, else a false brown-out trip follows
            if (rst) begin
               sync1_r[gi] <= SYNC_IDLE[gi];
               sync2_r[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1_r[gi] <= pins[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ls_prev_r <= 1'b0;
      end else begin
         ls_prev_r <= sync2_r[SYNC_LS];
      end
   end

   assign ls_tick = sync2_r[SYNC_LS] & ~ls_prev_r; // RULE25

   // Register state
   logic [7:0] bor_r,   bor_nxt;
   logic [7:0] cause_r, cause_nxt;
   logic [7:0] clk_r,   clk_nxt;
   logic [7:0] stat_r,  stat_nxt;
   logic [7:0] pwr_r,   pwr_nxt;
   logic [7:0] soft_r,  soft_nxt;
   logic [7:0] wto_r,   wto_nxt;
   logic [7:0] wen_r,   wen_nxt;
   logic [7:0] irqen_r, irqen_nxt;
   logic [7:0] irc1_r,  irc1_nxt;
   logic [7:0] irqpr_r, irqpr_nxt;
   logic [7:0] rdata_r, rdata_nxt;

   // Sequencer and watchdog state
   rmwc_state_t       st_r, st_nxt;
   logic [HOLD_W-1:0] hcnt_r, hcnt_nxt;
   logic [7:0]        cause_set;
   logic [WDT_W-1:0]  wcnt_r, wcnt_nxt;
   logic [WDT_W-1:0]  wdt_last;
   logic              clr_pend_r, clr_pend_nxt;
   logic              wdt_ovf;
   logic              wdt_run;
   logic              wdt_irq_ev;
   logic              wdt_rst_ev;
   logic              soft_ev;
   logic              bo_lvl;
   logic              prog_lvl;
   logic              wake_wait;
   logic              wake_lp;

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = sfr_wr && (sfr_addr == a);
   endfunction

   assign soft_ev    = wr_hit(ADDR_SOFT) && (sfr_wdata == KEY_VALUE); // RULE5
   assign bo_lvl     = ~sync2_r[SYNC_BO_N] & ~bor_r[BOR_DIS_BIT];     // RULE7
   assign prog_lvl   = sync2_r[SYNC_PROG];
   assign wdt_run    = (wen_r != KEY_VALUE);                          // RULE22
   assign wdt_irq_ev = wdt_ovf & pwr_r[LOWPWR_BIT];                   // RULE18
   assign wdt_rst_ev = wdt_ovf & ~pwr_r[LOWPWR_BIT];                  // RULE17
   assign wdt_last   = (WDT_BASE << wto_r[2:0]) - 17'h00001;          // RULE16

   // Global reset sequencer
   always_comb begin
      st_nxt    = st_r;
      hcnt_nxt  = hcnt_r;
      cause_set = RST_ZERO;
      cause_set[CAUSE_BO]   = bo_lvl;   // RULE2
      cause_set[CAUSE_PROG] = prog_lvl; // RULE1
      case (st_r)
         RMWC_RUN: begin
            if (bo_lvl || prog_lvl) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = HOLD_CYC;
            end else if (wdt_rst_ev) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = HOLD_CYC; // RULE6
               cause_set[CAUSE_WDT] = 1'b1; // RULE2
            end else if (soft_ev) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = HOLD_CYC;
               cause_set[CAUSE_SOFT] = 1'b1; // RULE1
            end else if (pc_overflow) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = HOLD_CYC;
               cause_set[CAUSE_PCOVF] = 1'b1; // RULE1
            end else if (debug_rst_req) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = DBG_HOLD_CYC;
               cause_set[CAUSE_DEBUG] = 1'b1; // RULE3
            end else if (boot_rst_req) begin
               st_nxt   = RMWC_HOLD;
               hcnt_nxt = BOOT_HOLD_CYC;
               cause_set[CAUSE_BOOT] = 1'b1; // RULE3
            end
         end
         RMWC_HOLD: begin
            if (bo_lvl || prog_lvl) begin
               hcnt_nxt = HOLD_CYC;
            end else if (hcnt_r <= DBG_HOLD_CYC) begin
               st_nxt = RMWC_RUN;
            end else begin
               hcnt_nxt = hcnt_r - DBG_HOLD_CYC;
            end
         end
         default: begin
            st_nxt   = RMWC_HOLD;
            hcnt_nxt = HOLD_CYC;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Power-on hold uses the same configured length as other sources except debug and boot
         st_r   <= RMWC_HOLD;
         hcnt_r <= HOLD_CYC;
      end else begin
         st_r   <= st_nxt;
         hcnt_r <= hcnt_nxt;
      end
   end

   assign glb_rst = (st_r == RMWC_HOLD);

   // Watchdog counter on low-speed ticks
   always_comb begin
      wcnt_nxt     = wcnt_r;
      wdt_ovf      = 1'b0;
      clr_pend_nxt = clr_pend_r & ~ls_tick; // RULE20
      if (glb_rst || wr_hit(ADDR_WTO)) begin
         clr_pend_nxt = 1'b1; // RULE19
      end
      if (clr_pend_r) begin
         wcnt_nxt = '0;
      end else if (wdt_run && ls_tick) begin
         if (wcnt_r >= wdt_last) begin
            wcnt_nxt = '0; // RULE21
            wdt_ovf  = 1'b1;
         end else begin
            wcnt_nxt = wcnt_r + 17'h00001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wcnt_r     <= '0;
         clr_pend_r <= 1'b1;
      end else begin
         wcnt_r     <= wcnt_nxt;
         clr_pend_r <= clr_pend_nxt;
      end
   end

   // Wake conditions
   assign wdt_timer2_irq = irc1_r[IRQ7_BIT] & irqen_r[IRQ7_BIT];     // RULE24
   assign wake_wait      = wake_wait_irq | wdt_timer2_irq;           // RULE12
   assign wake_lp        = wake_lp_irq | wdt_timer2_irq;             // RULE15

   // Register file
   always_comb begin
      bor_nxt   = bor_r;
      cause_nxt = cause_r;
      clk_nxt   = clk_r;
      stat_nxt  = stat_r;
      pwr_nxt   = pwr_r;
      soft_nxt  = soft_r;
      wto_nxt   = wto_r;
      wen_nxt   = wen_r;
      irqen_nxt = irqen_r;
      irc1_nxt  = irc1_r;
      irqpr_nxt = irqpr_r;
      rdata_nxt = rdata_r;
      if (wr_hit(ADDR_BOR)) begin
         bor_nxt = sfr_wdata & MASK_BOR; // RULE10
      end
      if (wr_hit(ADDR_CAUSE)) begin
         cause_nxt = sfr_wdata; // RULE4
      end
      cause_nxt = cause_nxt | cause_set;
      if (glb_rst) begin
         clk_nxt  = RST_CLKCFG;
         stat_nxt = RST_ZERO;
         pwr_nxt   = RST_ZERO;
         soft_nxt  = RST_ZERO;
         wto_nxt   = RST_ZERO;
         wen_nxt   = RST_ZERO; // RULE22
         irqen_nxt = RST_ZERO;
         irc1_nxt  = RST_ZERO;
         irqpr_nxt = RST_ZERO;
      end else begin
         if (wr_hit(ADDR_CLKCFG)) begin
            clk_nxt = sfr_wdata & MASK_CLKCFG; // RULE11
         end else if (clk_r[WAIT_BIT] && wake_wait) begin
            clk_nxt[WAIT_BIT] = 1'b0; // RULE12
         end
         if (wr_hit(ADDR_PWR)) begin
            pwr_nxt = sfr_wdata & MASK_PWR; // RULE13
         end else if (pwr_r[LOWPWR_BIT] && wake_lp) begin
            pwr_nxt[LOWPWR_BIT] = 1'b0; // RULE14
         end
         if (wr_hit(ADDR_SOFT)) begin
            soft_nxt = sfr_wdata;
         end
         if (wr_hit(ADDR_WTO)) begin
            wto_nxt = sfr_wdata & MASK_WTO;
            stat_nxt[STAT_WDT] = 1'b0; // RULE23
         end
         if (wr_hit(ADDR_WEN)) begin
            wen_nxt = sfr_wdata;
         end
         if (wr_hit(ADDR_STAT)) begin
            stat_nxt = sfr_wdata & MASK_STAT;
         end
         stat_nxt[STAT_WDT] = stat_nxt[STAT_WDT] | wdt_irq_ev; // RULE23
         stat_nxt[STAT_T2]  = stat_nxt[STAT_T2] | timer2_irq;
         if (wr_hit(ADDR_IRQEN)) begin
            irqen_nxt = sfr_wdata & MASK_IRQ;
         end
         if (wr_hit(ADDR_IRQPR)) begin
            irqpr_nxt = sfr_wdata & MASK_IRQ;
         end
         if (wr_hit(ADDR_IRC1)) begin
            irc1_nxt = sfr_wdata & MASK_IRQ;
         end
         irc1_nxt[IRQ7_BIT] = irc1_nxt[IRQ7_BIT] | wdt_irq_ev | timer2_irq; // RULE24
      end
      if (sfr_rd) begin
         case (sfr_addr) // RULE26
            ADDR_BOR:    rdata_nxt = bor_r;
            ADDR_CAUSE:  rdata_nxt = cause_r;
            ADDR_CLKCFG: rdata_nxt = clk_r;
            ADDR_STAT:   rdata_nxt = stat_r;
            ADDR_PWR:    rdata_nxt = pwr_r;
            ADDR_SOFT:   rdata_nxt = soft_r;
            ADDR_WTO:    rdata_nxt = wto_r;
            ADDR_WEN:    rdata_nxt = wen_r;
            ADDR_IRQEN:  rdata_nxt = irqen_r;
            ADDR_IRC1:   rdata_nxt = irc1_r;
            ADDR_IRQPR:  rdata_nxt = irqpr_r;
            default:     rdata_nxt = RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bor_r   <= RST_BOR; // RULE10
         cause_r <= RST_CAUSE; // RULE2
         clk_r   <= RST_CLKCFG;
         stat_r  <= RST_ZERO;
         pwr_r   <= RST_ZERO;
         soft_r  <= RST_ZERO;
         wto_r   <= RST_ZERO;
         wen_r   <= RST_ZERO;
         irqen_r <= RST_ZERO;
         irc1_r  <= RST_ZERO;
         irqpr_r <= RST_ZERO;
         rdata_r <= RST_ZERO;
      end else begin
         bor_r   <= bor_nxt;
         cause_r <= cause_nxt;
         clk_r   <= clk_nxt;
         stat_r  <= stat_nxt;
         pwr_r   <= pwr_nxt;
         soft_r  <= soft_nxt;
         wto_r   <= wto_nxt;
         wen_r   <= wen_nxt;
         irqen_r <= irqen_nxt;
         irc1_r  <= irc1_nxt;
         irqpr_r <= irqpr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Mode and analog controls
   assign sfr_rdata                 = rdata_r;
   assign wait_mode                 = clk_r[WAIT_BIT];                      // RULE11
   assign low_power_enter           = pwr_r[LOWPWR_BIT];                    // RULE13
   assign core_halt                 = clk_r[WAIT_BIT] | pwr_r[LOWPWR_BIT];
   assign periph_halt               = clk_r[WAIT_BIT] | pwr_r[LOWPWR_BIT];
   assign rc_1mhz_osc_off           = pwr_r[LOWPWR_BIT];
   assign brownout_disable          = bor_r[BOR_DIS_BIT];                   // RULE7
   assign brownout_delay_select     = bor_r[BOR_DLY_BIT];                   // RULE8
   assign brownout_threshold_select = bor_r[2:0];
   assign bor_level                 = rmwc_bor_level(bor_r[2:0]);           // RULE9
   assign irq_priority_1            = irqpr_r;

endmodule

// *** tb/rmwc_asserts.sv ***
// Concurrent checks on the reset, mode and watchdog controller ports
`timescale 1ns/1ns
module rmwc_asserts
   import rmwc_pkg::*;
(
   input wire logic       ref_clk,                   // Clock
   input wire logic       rst,                       // Reset
   input wire logic [7:0] sfr_addr,                  // Address
   input wire logic       sfr_wr,                    // Write
   input wire logic [7:0] sfr_wdata,                 // Data
   input wire logic       glb_rst,                   // Chip reset
   input wire logic       wait_mode,                 // Wait
   input wire logic       low_power_enter,           // Low power
   input wire logic       core_halt,                 // Halt
   input wire logic       rc_1mhz_osc_off,           // Osc off
   input wire logic       brownout_disable,          // Detector off
   input wire logic [2:0] brownout_threshold_select, // Trip code
   input wire logic [2:0] bor_level,                 // Level
   input wire logic       wdt_timer2_irq,            // Irq
   input wire logic       wake_wait_irq              // Wake
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence wr_to(a);
      sfr_wr && sfr_addr == a && !glb_rst;
   endsequence
   sequence soft_key;
      wr_to(ADDR_SOFT) ##0 sfr_wdata == KEY_VALUE;
   endsequence

   a_soft_key_reset: assert property (soft_key |=> glb_rst [*8])
      else $error("key write gave no held reset");
   a_wait_write: assert property (wr_to(ADDR_CLKCFG) |=>
      wait_mode == $past(sfr_wdata[2]))
      else $error("wait mode not taken from write");
   a_lowpwr_write: assert property (wr_to(ADDR_PWR) |=>
      low_power_enter == $past(sfr_wdata[0]))
      else $error("low power not taken from write");
   a_halt_follow: assert property (core_halt == (wait_mode | low_power_enter) &&
      rc_1mhz_osc_off == low_power_enter)
      else $error("halt outputs disagree with mode");
   a_bor_write: assert property (sfr_wr && sfr_addr == ADDR_BOR |=>
      {brownout_disable, brownout_threshold_select} ==
      {$past(sfr_wdata[4]), $past(sfr_wdata[2:0])})
      else $error("brownout fields not written");
   a_bor_hold: assert property (!(sfr_wr && sfr_addr == ADDR_BOR) |=>
      $stable({brownout_disable, brownout_threshold_select}))
      else $error("brownout fields changed unwritten");
   a_bor_decode: assert property (bor_level ==
      (brownout_threshold_select[2] ? 3'h4 : {1'b0, brownout_threshold_select[1:0]}))
      else $error("trip level decode wrong");
   a_wait_wake: assert property (wait_mode && wake_wait_irq && !sfr_wr |->
      ##[1:3] !wait_mode)
      else $error("wait mode not left on wake");
   a_lowpwr_wake: assert property (low_power_enter &&
      $rose(wdt_timer2_irq) && !sfr_wr |-> ##[1:3] !low_power_enter)
      else $error("low power bit not cleared on wake");
endmodule

bind rmwc_top rmwc_asserts rmwc_asserts_i (
   .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .glb_rst(glb_rst), .wait_mode(wait_mode),
   .low_power_enter(low_power_enter), .core_halt(core_halt),
   .rc_1mhz_osc_off(rc_1mhz_osc_off), .brownout_disable(brownout_disable),
   .brownout_threshold_select(brownout_threshold_select), .bor_level(bor_level),
   .wdt_timer2_irq(wdt_timer2_irq), .wake_wait_irq(wake_wait_irq)
);

// *** tb/reset_mode_watchdog_ctrl_test.sv ***
// Self-checking bench for the reset, mode and watchdog controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module reset_mode_watchdog_ctrl_test;
   import rmwc_pkg::*;
   localparam logic [HOLD_W-1:0] HC = 20'h00014;
   localparam logic [WDT_W-1:0]  WB = 17'h00004;
   logic       ref_clk = 0;
   logic       rst = 1;
   logic       sfr_wr = 0;
   logic       sfr_rd = 0;
   logic [7:0] sfr_addr = 0;
   logic [7:0] sfr_wdata = 0;
   logic [4:0] src = 0;
   logic       osc = 0;
   logic       osc_run = 0;
   logic [1:0] div = 0;
   logic       t2 = 0;
   logic       ww = 0;
   logic       wl = 0;
   int         num_errors = 0;
   int         num_checks = 0;
   wire  [7:0] sfr_rdata;
   wire  [7:0] ipl;
   wire        glb_rst, wait_mode, lowpwr, core_halt, periph_halt, osc_off, irq;
   wire        bdis, bdly;
   wire  [2:0] bthr, blvl;

   rmwc_top #(.HOLD_CYC(HC), .WDT_BASE(WB)) rmwc_top_i (
      .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .low_speed_osc(osc), .bor_trip_n(~src[4]), .prog_en(src[3]),
      .pc_overflow(src[0]), .debug_rst_req(src[1]), .boot_rst_req(src[2]),
      .timer2_irq(t2), .wake_wait_irq(ww), .wake_lp_irq(wl), .glb_rst(glb_rst),
      .wait_mode(wait_mode), .low_power_enter(lowpwr), .core_halt(core_halt),
      .periph_halt(periph_halt), .rc_1mhz_osc_off(osc_off),
      .brownout_disable(bdis), .brownout_delay_select(bdly),
      .brownout_threshold_select(bthr), .bor_level(blvl),
      .wdt_timer2_irq(irq), .irq_priority_1(ipl));

   always #10 ref_clk = ~ref_clk;
   // Low-speed clock at one eighth of the system rate
   always @(posedge ref_clk) begin
      div <= div + 2'h1;
      if (osc_run && div == 2'h3)
         osc <= ~osc;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1 `CHK("register read", e, sfr_rdata)
   endtask
   task automatic wglb(input logic v, input int lim, output int n);
      n = 0;
      while (glb_rst !== v && n < lim) begin
         @(posedge ref_clk);
         #1 n++;
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic t_reset();
      logic [7:0] ra[12] = '{8'h2e, 8'h84, 8'h85, 8'h87, 8'h8e, 8'h91, 8'h92, 8'hd7,
                              8'he6, 8'hf1, 8'hf6, 8'h00};
      logic [7:0] rv[12] = '{8'h18, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
                              8'h00, 8'h00, 8'h00, 8'h00};
      int n;
      wglb(1'b0, 100, n);
      `CHK("reset hold", 1'b1, n >= HC - 2 && n <= HC + 4)
      for (int i = 0; i < 12; i++)
         rchk(ra[i], rv[i]);
      `CHK("bor outputs", 5'h18, {bdis, bdly, bthr})
      $display("reset values done");
   endtask

   task automatic t_bor();
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_BOR, 8'(i));
         tick(1);
         `CHK("trip level", (i > 3) ? 3'h4 : 3'(i), blvl)
      end
      wr(ADDR_BOR, 8'h08);
      tick(1);
      `CHK("bor fields", 5'h08, {bdis, bdly, bthr})
      $display("brownout config done");
   endtask

   task automatic t_soft();
      int n;
      wr(ADDR_CAUSE, 8'h00);
      wr(ADDR_SOFT, 8'h54);
      tick(4);
      `CHK("no soft reset", 1'b0, glb_rst)
      wr(ADDR_SOFT, 8'h55);
      tick(1);
      `CHK("soft reset", 1'b1, glb_rst)
      wglb(1'b0, 100, n);
      rchk(ADDR_CAUSE, 8'h20);
      rchk(ADDR_BOR, 8'h08);
      $display("soft reset done");
   endtask

   task automatic t_src();
      logic [7:0] ex[5] = '{8'h08, 8'h40, 8'h80, 8'h10, 8'h04};
      int n;
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CAUSE, 8'h00);
         src[i] <= 1'b1;
         tick(2);
         src[i] <= 1'b0;
         tick(4);
         wglb(1'b0, 100, n);
         rchk(ADDR_CAUSE, ex[i]);
      end
      $display("reset sources done");
   endtask

   task automatic t_mode();
      wr(ADDR_CLKCFG, 8'h05);
      tick(1);
      `CHK("wait halts", 4'he, {wait_mode, core_halt, periph_halt, osc_off})
      rchk(ADDR_CLKCFG, 8'h05);
      ww <= 1'b1;
      tick(3);
      ww <= 1'b0;
      `CHK("wait wake", 1'b0, wait_mode)
      wr(ADDR_PWR, 8'h01);
      tick(1);
      `CHK("low power", 2'h3, {lowpwr, osc_off})
      wl <= 1'b1;
      tick(3);
      wl <= 1'b0;
      rchk(ADDR_PWR, 8'h00);
      wr(ADDR_IRQPR, 8'hff);
      tick(1);
      `CHK("priority", MASK_IRQ, ipl)
      $display("working modes done");
   endtask

   task automatic t_wdt();
      int n;
      int lim;
      wr(ADDR_CAUSE, 8'h00);
      osc_run = 1;
      wr(ADDR_WTO, 8'h00);
      wglb(1'b1, 300, n);
      lim = int'(WB) * 8;
      `CHK("timeout 0", 1'b1, n >= lim - 20 && n <= lim + 28)
      osc_run = 0;
      wglb(1'b0, 100, n);
      `CHK("wdt reset hold", 1'b1, n >= HC - 2 && n <= HC + 2)
      rchk(ADDR_CAUSE, 8'h01);
      wr(ADDR_CAUSE, 8'h00);
      osc_run = 1;
      repeat (4) begin
         wr(ADDR_WTO, 8'h01);
         tick(40);
      end
      wr(ADDR_WTO, 8'h01);
      rchk(ADDR_CAUSE, 8'h00);
      wglb(1'b1, 300, n);
      `CHK("timeout 1", 1'b1, n >= 2 * lim - 20 && n <= 2 * lim + 28)
      osc_run = 0;
      wglb(1'b0, 100, n);
      wr(ADDR_WEN, 8'h55);
      osc_run = 1;
      wr(ADDR_WTO, 8'h00);
      wglb(1'b1, 150, n);
      `CHK("stopped", 1'b1, n == 150)
      wr(ADDR_WEN, 8'h00);
      wr(ADDR_IRQEN, 8'h80);
      wr(ADDR_PWR, 8'h01);
      wr(ADDR_WTO, 8'h00);
      n = 0;
      while (irq !== 1'b1 && n < 150) begin
         @(posedge ref_clk);
         #1 n++;
      end
      `CHK("wdt irq", 2'h2, {irq, glb_rst})
      tick(2);
      `CHK("low power woken", 1'b0, lowpwr)
      wr(ADDR_WEN, 8'h55);
      rchk(ADDR_STAT, 8'h02);
      rchk(ADDR_IRC1, 8'h80);
      wr(ADDR_WTO, 8'h00);
      rchk(ADDR_STAT, 8'h00);
      wr(ADDR_IRC1, 8'h00);
      tick(1);
      `CHK("irq cleared", 1'b0, irq)
      osc_run = 0;
      t2 <= 1'b1;
      tick(1);
      t2 <= 1'b0;
      rchk(ADDR_STAT, 8'h01);
      `CHK("timer2 irq", 1'b1, irq)
      $display("watchdog done");
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_bor();
      t_soft();
      t_src();
      t_mode();
      t_wdt();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      wrap_up();
   end
endmodule
